// ===== src/dpit_top.sv
// Dual target two-wire interface: two target engines on the bus clock and a
// firmware-side event port on the system clock.
// Assumes pads resolve open-drain lines from the enables and that firmware
// sets the address masks before raising boot completion.
//
// Overview of operation
// R1: Three ports; first is controller or target, second target only, third controller only.
// R2: Target ports handle standard and fast bus speeds.
// R3: Pads drive lines open-drain only and sense through a deglitch filter.
// R4: Controller starts a transfer only while the bus is idle.
// R5: Data falling with clock high is start; rising with clock high is stop.
// R6: Address byte arrives most significant bit first, direction bit last.
// R7: Matching address is acknowledged by holding data low through the ninth pulse.
// R8: One bit per clock pulse; data changes only while the clock is low.
// R9: Any number of bytes between start and stop, each eight bits plus acknowledge.
// R10: The transmitter releases data before the acknowledge slot.
// R11: As receiver the target acknowledges every byte.
// R12: Reading controller acknowledges every byte except the last.
// R13: Controller ends a read by leaving data high in the acknowledge slot.
// R14: After a not-acknowledge the target stops sending and releases data.
// R15: Target may hold the clock low while not ready for more data.
// R16: Controller waits until it actually sees the clock go high.
// R17: Controller waits 4 us at 100 kbps after the rise before pulling clock low.
// R18: Each target port answers two addresses, one per power-delivery port.
// R19: Addresses are set at boot; no response to bus traffic before that.
// R20: First port addresses follow the address-select analog level.
// R21: Address byte holds address in bits seven to one, direction in bit zero.
// R22: Firmware may mask any address bit per port, overriding the hardware value.
// R23: Second port addresses are fixed values.
// R24: Select level sets address byte bits three to one; other bits fixed.
// R25: Unmatched address is not acknowledged; lines stay released until next start.
// R26: Repeated start resets counters and begins a new address phase.
module dpit_top (
  // Clocks and reset
  input  wire logic                                    sys_clk_i,
  input  wire logic                                    link_clk_i,
  input  wire logic                                    rst_b_i,
  // Boot and configuration
  input  wire logic                                    boot_done_i,
  input  wire logic [dpit_pkg::ADDR_LVL_W-1:0]         addr_sel_lvl_i,
  input  dpit_pkg::dpit_addr_cfg_t [1:0][1:0]          addr_cfg_i,
  input  wire logic                                    first_port_ctrl_role_i,
  output logic                                         addr_ready_o,
  // Bus pads
  input  dpit_pkg::dpit_pad_in_t [dpit_pkg::NUM_TGT-1:0]  pad_i,
  output dpit_pkg::dpit_pad_out_t [dpit_pkg::NUM_TGT-1:0] pad_o,
  // Firmware event port
  output logic [dpit_pkg::NUM_TGT-1:0]                 evt_valid_o,
  output dpit_pkg::dpit_evt_t [dpit_pkg::NUM_TGT-1:0]  evt_o,
  input  wire logic [dpit_pkg::NUM_TGT-1:0]            evt_done_i,
  input  wire logic [dpit_pkg::NUM_TGT-1:0][7:0]       tx_byte_i
);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    dpit_pkg::dpit_tstate_t st;
    logic [3:0]             bitcnt;
    logic [7:0]             shreg;
    logic                   is_read;
    logic                   pd_sel;
    logic                   first;
    logic                   req_tgl;
    logic                   ans_s1;
    logic                   ans_s2;
    logic                   ans_seen;
    logic                   scl_prev;
    logic                   sda_prev;
    logic                   scl_oe;
    logic                   sda_oe;
  } dpit_tgt_t;

  typedef struct packed {
    dpit_tgt_t [1:0] tgt;
    logic            ready_s1;
    logic            ready_s2;
    logic            role_s1;
    logic            role_s2;
  } dpit_link_state_t;

  typedef struct packed {
    logic                            boot_q;
    logic                            ready;
    logic [1:0][1:0][6:0]            addr;
    logic [1:0]                      req_s1;
    logic [1:0]                      req_s2;
    logic [1:0]                      req_seen;
    logic [1:0]                      ans_tgl;
    logic [1:0][7:0]                 tx;
    logic [1:0]                      evt_valid;
    dpit_pkg::dpit_evt_t [1:0]       evt;
  } dpit_sys_state_t;

  dpit_link_state_t lq;
  dpit_link_state_t ld;
  dpit_sys_state_t  sq;
  dpit_sys_state_t  sd;

  logic [1:0]                scl_f;
  logic [1:0]                sda_f;
  logic [1:0]                en_c;
  logic [1:0]                rise_c;
  logic [1:0]                fall_c;
  logic [1:0]                start_c;
  logic [1:0]                stop_c;
  logic [1:0]                ans_new_c;
  dpit_pkg::dpit_evt_t [1:0] evt_l;

  // ****************************************************************
  // Address arithmetic
  // ****************************************************************
  function automatic logic [6:0] lvl_addr(input logic [6:0] base, input logic [1:0] lvl);
    logic [2:0] low;
    low = 3'(base[2:0] + {1'b0, lvl});
    return {base[6:3], low}; // R24
  endfunction

  function automatic logic [6:0] apply_mask(input logic [6:0] hw, input dpit_pkg::dpit_addr_cfg_t cfg);
    return (hw & ~cfg.mask) | (cfg.value & cfg.mask); // R22
  endfunction

  // ****************************************************************
  // Line conditioning and bus conditions
  // ****************************************************************
  for (genvar p = 0; p < dpit_pkg::NUM_TGT; p++) begin : g_line
    // The filter window is short enough for fast-mode clock highs.
    dpit_line_filter u_scl_filt ( // R3 R2
      .link_clk_i (link_clk_i),
      .rst_b_i    (rst_b_i),
      .line_i     (pad_i[p].scl),
      .line_o     (scl_f[p])
    );
    dpit_line_filter u_sda_filt (
      .link_clk_i (link_clk_i),
      .rst_b_i    (rst_b_i),
      .line_i     (pad_i[p].sda),
      .line_o     (sda_f[p])
    );
    // The first port stays quiet while firmware uses it as a controller.
    assign en_c[p]      = lq.ready_s2 && !((p == 0) && lq.role_s2); // R1 R19
    assign rise_c[p]    = scl_f[p] && !lq.tgt[p].scl_prev; // R8
    assign fall_c[p]    = !scl_f[p] && lq.tgt[p].scl_prev;
    assign start_c[p]   = scl_f[p] && lq.tgt[p].scl_prev && !sda_f[p] && lq.tgt[p].sda_prev; // R5
    assign stop_c[p]    = scl_f[p] && lq.tgt[p].scl_prev && sda_f[p] && !lq.tgt[p].sda_prev; // R5
    assign ans_new_c[p] = lq.tgt[p].ans_s2 != lq.tgt[p].ans_seen;
    assign evt_l[p]     = '{is_read: lq.tgt[p].is_read, pd_sel: lq.tgt[p].pd_sel,
                            first: lq.tgt[p].first, data: lq.tgt[p].shreg};
    assign pad_o[p]     = '{scl_o: 1'b0, scl_oe: lq.tgt[p].scl_oe, sda_o: 1'b0, sda_oe: lq.tgt[p].sda_oe}; // R3
  end

  // ****************************************************************
  // Bus-side target engines
  // ****************************************************************
  always_comb begin
    ld          = lq;
    ld.ready_s1 = sq.ready;
    ld.ready_s2 = lq.ready_s1;
    ld.role_s1  = first_port_ctrl_role_i;
    ld.role_s2  = lq.role_s1;
    for (int p = 0; p < dpit_pkg::NUM_TGT; p++) begin
      ld.tgt[p].scl_prev = scl_f[p];
      ld.tgt[p].sda_prev = sda_f[p];
      ld.tgt[p].ans_s1   = sq.ans_tgl[p];
      ld.tgt[p].ans_s2   = lq.tgt[p].ans_s1;
      if (!en_c[p]) begin
        ld.tgt[p].st     = dpit_pkg::TS_IDLE; // R19
        ld.tgt[p].scl_oe = 1'b0;
        ld.tgt[p].sda_oe = 1'b0;
      end else if (start_c[p]) begin
        ld.tgt[p].st     = dpit_pkg::TS_ADDR; // R26
        ld.tgt[p].bitcnt = '0;
        ld.tgt[p].first  = 1'b1;
        ld.tgt[p].scl_oe = 1'b0;
        ld.tgt[p].sda_oe = 1'b0;
      end else if (stop_c[p]) begin
        ld.tgt[p].st     = dpit_pkg::TS_IDLE;
        ld.tgt[p].scl_oe = 1'b0;
        ld.tgt[p].sda_oe = 1'b0;
      end else begin
        unique case (lq.tgt[p].st)
          dpit_pkg::TS_IDLE, dpit_pkg::TS_IGNORE: begin
            ld.tgt[p].scl_oe = 1'b0; // R25
            ld.tgt[p].sda_oe = 1'b0;
          end
          dpit_pkg::TS_ADDR: begin
            if (rise_c[p]) begin
              ld.tgt[p].shreg  = {lq.tgt[p].shreg[6:0], sda_f[p]}; // R6
              ld.tgt[p].bitcnt = lq.tgt[p].bitcnt + 4'h1;
            end else if (fall_c[p] && lq.tgt[p].bitcnt == dpit_pkg::BIT_CNT_FULL) begin
              ld.tgt[p].bitcnt  = '0;
              ld.tgt[p].is_read = lq.tgt[p].shreg[dpit_pkg::ADDR_BYTE_RW_BIT]; // R21
              ld.tgt[p].pd_sel  = lq.tgt[p].shreg[7:dpit_pkg::ADDR_BYTE_ADDR_LSB] == sq.addr[p][1]; // R18
              if (lq.tgt[p].shreg[7:dpit_pkg::ADDR_BYTE_ADDR_LSB] == sq.addr[p][0] ||
                  lq.tgt[p].shreg[7:dpit_pkg::ADDR_BYTE_ADDR_LSB] == sq.addr[p][1]) begin
                ld.tgt[p].st     = dpit_pkg::TS_ADDR_ACK;
                ld.tgt[p].sda_oe = 1'b1; // R7
              end else begin
                ld.tgt[p].st = dpit_pkg::TS_IGNORE; // R25
              end
            end
          end
          dpit_pkg::TS_ADDR_ACK: begin
            if (fall_c[p]) begin
              ld.tgt[p].sda_oe = 1'b0;
              if (lq.tgt[p].is_read) begin
                ld.tgt[p].st      = dpit_pkg::TS_TX_WAIT;
                ld.tgt[p].scl_oe  = 1'b1; // R15
                ld.tgt[p].req_tgl = !lq.tgt[p].req_tgl;
              end else begin
                ld.tgt[p].st = dpit_pkg::TS_RX_BITS;
              end
            end
          end
          dpit_pkg::TS_RX_BITS: begin
            if (rise_c[p]) begin
              ld.tgt[p].shreg  = {lq.tgt[p].shreg[6:0], sda_f[p]}; // R8
              ld.tgt[p].bitcnt = lq.tgt[p].bitcnt + 4'h1;
            end else if (fall_c[p] && lq.tgt[p].bitcnt == dpit_pkg::BIT_CNT_FULL) begin
              // The byte is held until firmware takes it, so the clock is stretched.
              ld.tgt[p].bitcnt  = '0; // R9
              ld.tgt[p].st      = dpit_pkg::TS_RX_WAIT;
              ld.tgt[p].scl_oe  = 1'b1; // R15
              ld.tgt[p].sda_oe  = 1'b1; // R11
              ld.tgt[p].req_tgl = !lq.tgt[p].req_tgl;
            end
          end
          dpit_pkg::TS_RX_WAIT: begin
            if (ans_new_c[p]) begin
              ld.tgt[p].ans_seen = lq.tgt[p].ans_s2;
              ld.tgt[p].first    = 1'b0;
              ld.tgt[p].scl_oe   = 1'b0; // R16
              ld.tgt[p].st       = dpit_pkg::TS_RX_ACK;
            end
          end
          dpit_pkg::TS_RX_ACK: begin
            if (fall_c[p]) begin
              ld.tgt[p].sda_oe = 1'b0;
              ld.tgt[p].st     = dpit_pkg::TS_RX_BITS;
            end
          end
          dpit_pkg::TS_TX_WAIT: begin
            if (ans_new_c[p]) begin
              ld.tgt[p].ans_seen = lq.tgt[p].ans_s2;
              ld.tgt[p].first    = 1'b0;
              ld.tgt[p].shreg    = sq.tx[p];
              ld.tgt[p].sda_oe   = !sq.tx[p][7];
              ld.tgt[p].bitcnt   = '0;
              ld.tgt[p].scl_oe   = 1'b0; // R16
              ld.tgt[p].st       = dpit_pkg::TS_TX_BITS;
            end
          end
          dpit_pkg::TS_TX_BITS: begin
            if (fall_c[p]) begin
              ld.tgt[p].bitcnt = lq.tgt[p].bitcnt + 4'h1; // R8
              if (lq.tgt[p].bitcnt == dpit_pkg::BIT_CNT_LAST) begin
                ld.tgt[p].sda_oe = 1'b0; // R10
                ld.tgt[p].st     = dpit_pkg::TS_TX_ACK;
              end else begin
                ld.tgt[p].shreg  = {lq.tgt[p].shreg[6:0], 1'b0};
                ld.tgt[p].sda_oe = !lq.tgt[p].shreg[6];
              end
            end
          end
          dpit_pkg::TS_TX_ACK: begin
            if (rise_c[p]) begin
              ld.tgt[p].st = sda_f[p] ? dpit_pkg::TS_IGNORE : dpit_pkg::TS_TX_ACKED; // R13 R14
            end
          end
          dpit_pkg::TS_TX_ACKED: begin
            if (fall_c[p]) begin
              ld.tgt[p].st      = dpit_pkg::TS_TX_WAIT;
              ld.tgt[p].scl_oe  = 1'b1; // R15
              ld.tgt[p].req_tgl = !lq.tgt[p].req_tgl;
            end
          end
          default: begin
            ld.tgt[p].st     = dpit_pkg::TS_IDLE;
            ld.tgt[p].scl_oe = 1'b0;
            ld.tgt[p].sda_oe = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // ****************************************************************
  // Firmware side: boot capture and event handshake
  // ****************************************************************
  // Event fields are read across the clock boundary only after the request
  // toggle has passed two flops; the bus side holds them until answered.
  always_comb begin
    sd        = sq;
    sd.boot_q = boot_done_i;
    if (boot_done_i && !sq.boot_q && !sq.ready) begin
      sd.ready      = 1'b1; // R19
      sd.addr[0][0] = apply_mask(lvl_addr(dpit_pkg::P1_PD1_BASE, addr_sel_lvl_i), addr_cfg_i[0][0]); // R20
      sd.addr[0][1] = apply_mask(lvl_addr(dpit_pkg::P1_PD2_BASE, addr_sel_lvl_i), addr_cfg_i[0][1]); // R20
      sd.addr[1][0] = apply_mask(dpit_pkg::P2_PD1_ADDR, addr_cfg_i[1][0]); // R23
      sd.addr[1][1] = apply_mask(dpit_pkg::P2_PD2_ADDR, addr_cfg_i[1][1]); // R23
    end
    for (int p = 0; p < dpit_pkg::NUM_TGT; p++) begin
      sd.req_s1[p] = lq.tgt[p].req_tgl;
      sd.req_s2[p] = sq.req_s1[p];
      if (sq.evt_valid[p] && evt_done_i[p]) begin
        sd.evt_valid[p] = 1'b0;
        sd.tx[p]        = tx_byte_i[p];
        sd.ans_tgl[p]   = !sq.ans_tgl[p];
      end else if (!sq.evt_valid[p] && sq.req_s2[p] != sq.req_seen[p]) begin
        sd.evt_valid[p] = 1'b1;
        sd.evt[p]       = evt_l[p];
        sd.req_seen[p]  = sq.req_s2[p];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  assign addr_ready_o = sq.ready;
  assign evt_valid_o  = sq.evt_valid;
  assign evt_o        = sq.evt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_boot_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R23
    boot_done_i && !sq.boot_q && !sq.ready |=>
      sq.ready && sq.addr[1][0] == apply_mask(dpit_pkg::P2_PD1_ADDR, $past(addr_cfg_i[1][0])))
    else $error("Addresses not captured at boot completion.");

  for (genvar p = 0; p < dpit_pkg::NUM_TGT; p++) begin : g_chk
    a_boot_silence: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R19
      !lq.ready_s2 |-> !pad_o[p].sda_oe && !pad_o[p].scl_oe)
      else $error("Bus driven before boot completion.");

    a_pad_open_drain: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R3
      pad_o[p].sda_oe || pad_o[p].scl_oe |-> !pad_o[p].sda_o && !pad_o[p].scl_o)
      else $error("Pad drives a high level.");

    a_start_to_addr: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R26
      en_c[p] && start_c[p] |=> lq.tgt[p].st == dpit_pkg::TS_ADDR && lq.tgt[p].bitcnt == 4'h0 &&
        !pad_o[p].sda_oe)
      else $error("Start did not open an address phase.");

    a_stop_to_idle: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R5
      en_c[p] && stop_c[p] && !start_c[p] |=> lq.tgt[p].st == dpit_pkg::TS_IDLE ##1 !pad_o[p].scl_oe)
      else $error("Stop not honoured.");

    a_addr_msb_first: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R6
      en_c[p] && lq.tgt[p].st == dpit_pkg::TS_ADDR && rise_c[p] && !start_c[p] && !stop_c[p] |=>
        lq.tgt[p].shreg == {$past(lq.tgt[p].shreg[6:0]), $past(sda_f[p])})
      else $error("Address bit shifted in wrong order.");

    a_ack_on_match: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R7
      lq.tgt[p].st == dpit_pkg::TS_ADDR_ACK |-> pad_o[p].sda_oe)
      else $error("Address acknowledge not held.");

    a_ignore_quiet: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R25
      lq.tgt[p].st == dpit_pkg::TS_IGNORE && $past(lq.tgt[p].st) == dpit_pkg::TS_IGNORE |->
        !pad_o[p].sda_oe && !pad_o[p].scl_oe)
      else $error("Unaddressed target drives the bus.");

    a_rx_ack_held: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R11
      lq.tgt[p].st == dpit_pkg::TS_RX_WAIT |-> pad_o[p].sda_oe && pad_o[p].scl_oe)
      else $error("Received byte not acknowledged while stretched.");

    a_release_before_ack: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R10
      lq.tgt[p].st == dpit_pkg::TS_TX_ACK |-> !pad_o[p].sda_oe)
      else $error("Data line held in read acknowledge slot.");

    a_not_acknowledge_bit_releases: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R14
      en_c[p] && lq.tgt[p].st == dpit_pkg::TS_TX_ACK && rise_c[p] && sda_f[p] && !stop_c[p] |=>
        lq.tgt[p].st == dpit_pkg::TS_IGNORE ##1 !pad_o[p].sda_oe[*2])
      else $error("Target kept sending after not-acknowledge.");

    a_stretch_hold: assert property (@(posedge link_clk_i) disable iff (!rst_b_i) // R15
      lq.tgt[p].st == dpit_pkg::TS_TX_WAIT && !ans_new_c[p] && en_c[p] && !start_c[p] && !stop_c[p] |=>
        pad_o[p].scl_oe)
      else $error("Clock released before data was ready.");
  end

endmodule

// ===== src/dpit_pkg.sv
// Shared constants and types for the dual target two-wire interface.
// Assumes a 125 MHz system clock and a separate bus-side clock of about 33 MHz.
package dpit_pkg;

  // ****************************************************************
  // Clocks and line filtering
  // ****************************************************************
  localparam int SYS_CLK_PERIOD_PS  = 8000;
  localparam int LINK_CLK_PERIOD_PS = 30000;
  // Spike width that the line filter suppresses, in nanoseconds.
  localparam int GLITCH_NS          = 50;
  localparam int GLITCH_CYC_RAW     = (GLITCH_NS * 1000 + LINK_CLK_PERIOD_PS - 1) / LINK_CLK_PERIOD_PS;
  localparam int GLITCH_CYC         = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
  localparam int GLITCH_CNT_W       = 3;

  // ****************************************************************
  // Ports and address layout
  // ****************************************************************
  localparam int NUM_TGT            = 2;
  localparam int BYTE_BITS          = 8;
  localparam int ADDR_W             = 7;
  localparam int ADDR_LVL_W         = 2;
  localparam int ADDR_BYTE_RW_BIT   = 0;
  localparam int ADDR_BYTE_ADDR_LSB = 1;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;

  // Address bases; the decoded select level is added into the low three bits.
  localparam logic [6:0] P1_PD1_BASE = 7'h20;
  localparam logic [6:0] P1_PD2_BASE = 7'h24;
  // The second target port answers fixed addresses.
  localparam logic [6:0] P2_PD1_ADDR = 7'h38;
  localparam logic [6:0] P2_PD2_ADDR = 7'h3F;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic scl;
    logic sda;
  } dpit_pad_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } dpit_pad_out_t;

  typedef struct packed {
    logic [6:0] mask;
    logic [6:0] value;
  } dpit_addr_cfg_t;

  typedef struct packed {
    logic       is_read;
    logic       pd_sel;
    logic       first;
    logic [7:0] data;
  } dpit_evt_t;

  typedef enum logic [3:0] {
    TS_IDLE,
    TS_ADDR,
    TS_ADDR_ACK,
    TS_RX_BITS,
    TS_RX_WAIT,
    TS_RX_ACK,
    TS_TX_WAIT,
    TS_TX_BITS,
    TS_TX_ACK,
    TS_TX_ACKED,
    TS_IGNORE
  } dpit_tstate_t;

endpackage

// ===== src/dpit_line_filter.sv
// Two-stage synchroniser and deglitch filter for one bus line.
// Assumes the line idles high through its pull-up.
module dpit_line_filter (
  // Clock and reset
  input  wire logic link_clk_i,
  input  wire logic rst_b_i,
  // Line
  input  wire logic line_i,
  output logic      line_o
);

  typedef struct packed {
    logic [1:0]                            sync;
    logic [dpit_pkg::GLITCH_CNT_W-1:0]     cnt;
    logic                                  level;
  } dpit_filt_state_t;

  dpit_filt_state_t q;
  dpit_filt_state_t d;

  // A new level is accepted only after it stands for the whole glitch window.
  always_comb begin
    d         = q;
    d.sync[0] = line_i;
    d.sync[1] = q.sync[0];
    if (q.sync[1] == q.level) begin
      d.cnt = '0;
    end else if (q.cnt == dpit_pkg::GLITCH_CNT_W'(dpit_pkg::GLITCH_CYC - 1)) begin
      d.cnt   = '0;
      d.level = q.sync[1];
    end else begin
      d.cnt = q.cnt + 3'h1;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{sync: 2'h3, cnt: '0, level: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign line_o = q.level;

endmodule

// ===== tb/dpit_bus_ctrl.sv
// Bus controller model driving one shared two-wire bus.
// Assumes the bench pulls both lines up and adds the target enables.
module dpit_bus_ctrl (
  // Resolved lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Releases
  output logic      scl_rel_o,
  output logic      sda_rel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PH = 300;
  initial {scl_rel_o, sda_rel_o} = 2'h3;
  // Data moves only half a phase after the fall, so the filters never see it as start or stop.
  task automatic pulse(output logic b);
    #PH scl_rel_o = 1'b1;
    wait (scl_i === 1'b1);
    #PH b = sda_i;
    scl_rel_o = 1'b0;
    #(PH / 2);
  endtask
  task automatic start();
    sda_rel_o = 1'b1;
    #PH scl_rel_o = 1'b1;
    wait (scl_i === 1'b1);
    #PH sda_rel_o = 1'b0;
    #PH scl_rel_o = 1'b0;
    #(PH / 2);
  endtask
  task automatic stop();
    sda_rel_o = 1'b0;
    #PH scl_rel_o = 1'b1;
    wait (scl_i === 1'b1);
    #PH sda_rel_o = 1'b1;
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_rel_o = v[i];
      pulse(ack);
    end
    sda_rel_o = 1'b1;
    pulse(ack);
    ack = ~ack;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] v);
    logic a;
    sda_rel_o = 1'b1;
    for (int i = 7; i >= 0; i--) pulse(v[i]);
    sda_rel_o = last;
    pulse(a);
    sda_rel_o = 1'b1;
  endtask
endmodule

// ===== tb/dpit_top_test.sv
// Self-checking bench for the dual target two-wire interface.
// Assumes both target ports share one bus driven by the controller model.
module dpit_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                sys_clk_i, link_clk_i, rst_b_i, boot_done_i, addr_ready_o, scl, sda, ack;
  logic [1:0]                          lvl, evt_valid_o, evt_done_i;
  logic [1:0][7:0]                     tx_byte_i;
  dpit_pkg::dpit_addr_cfg_t [1:0][1:0] cfg;
  dpit_pkg::dpit_pad_out_t [1:0]       pad_o;
  dpit_pkg::dpit_evt_t [1:0]           evt_o;
  logic [11:0]                         evq[$];
  logic [11:0]                         ev;
  logic [7:0]                          rdq[$];
  logic [31:0]                         rs;
  int                                  failures, checks;
  logic                                role;
  wire logic                           scl_rel, sda_rel;
  assign scl = scl_rel & ~pad_o[0].scl_oe & ~pad_o[1].scl_oe;
  assign sda = sda_rel & ~pad_o[0].sda_oe & ~pad_o[1].sda_oe;
  dpit_bus_ctrl u_ctl (.scl_i(scl), .sda_i(sda), .scl_rel_o(scl_rel), .sda_rel_o(sda_rel));
  dpit_top u_dut (.sys_clk_i(sys_clk_i), .link_clk_i(link_clk_i), .rst_b_i(rst_b_i), .boot_done_i(boot_done_i),
    .addr_sel_lvl_i(lvl), .addr_cfg_i(cfg), .first_port_ctrl_role_i(role), .addr_ready_o(addr_ready_o),
    .pad_i({scl, sda, scl, sda}), .pad_o(pad_o), .evt_valid_o(evt_valid_o), .evt_o(evt_o),
    .evt_done_i(evt_done_i), .tx_byte_i(tx_byte_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  function automatic logic [7:0] nxt();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Notes are queued before the address goes out, since the first event can beat the task back.
  task automatic xfer(input logic [6:0] a, input logic rd, input int n, input logic hit, input logic [1:0] pp);
    logic [7:0] q[$];
    logic [7:0] b;
    for (int i = 0; i < n && hit; i++) begin
      q.push_back(nxt());
      evq.push_back({pp[1], rd, pp[0], i == 0, rd ? 8'h00 : q[i]});
    end
    u_ctl.start();
    u_ctl.wbyte({a, rd}, ack);
    chk("address ack", {11'h0, hit}, {11'h0, ack});
    foreach (q[i]) begin
      if (rd) begin
        u_ctl.rbyte(i == q.size() - 1, b);
        chk("read byte", rdq.size() ? {4'h0, rdq.pop_front()} : 12'hFFF, {4'h0, b});
      end else begin
        u_ctl.wbyte(q[i], ack);
        chk("write ack", 12'h001, {11'h0, ack});
      end
    end
    $display("test done for address %h", a);
  endtask
  always @(posedge sys_clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (evt_valid_o[p] === 1'b1 && evt_done_i[p] === 1'b0) begin
        ev = {p[0], evt_o[p]} & {4'hF, {8{~evt_o[p].is_read}}};
        chk("event", evq.size() ? evq.pop_front() : 12'hFFF, ev);
        if (evt_o[p].is_read) begin
          tx_byte_i[p] <= nxt();
          rdq.push_back(rs[7:0]);
        end
      end
      evt_done_i[p] <= evt_valid_o[p] === 1'b1 && evt_done_i[p] === 1'b0;
    end
  end
  initial begin
    #600_000;
    failures++;
    close_out();
  end
  initial begin
    rs = 32'h0000DEEE;
    void'(nxt());
    lvl = rs[1:0];
    {rst_b_i, boot_done_i, evt_done_i, tx_byte_i, cfg, role} = '0;
    cfg[0][1] = {7'h7F, 7'h50};
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    xfer(7'h38, 1'b0, 1, 1'b0, 2'h2);
    @(posedge sys_clk_i);
    boot_done_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    chk("ready", 12'h001, {11'h0, addr_ready_o});
    #500;
    xfer({5'h08, lvl}, 1'b0, 3, 1'b1, 2'h0);
    xfer(7'h50, 1'b0, 1, 1'b1, 2'h1);
    xfer({5'h09, lvl}, 1'b0, 1, 1'b0, 2'h1);
    xfer(7'h3F, 1'b0, 2, 1'b1, 2'h3);
    // With the first port in the controller role its target must stay silent.
    role <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    xfer({5'h08, lvl}, 1'b0, 1, 1'b0, 2'h0);
    role <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    xfer(7'h38, 1'b1, 3, 1'b1, 2'h2);
    #300;
    chk("release", 12'h000, {10'h0, pad_o[1].sda_oe, pad_o[1].scl_oe});
    u_ctl.stop();
    close_out();
  end
endmodule
